// ===== core/adc_ctl_pkg.sv
// constants, types and helpers shared by the converter control files
package adc_ctl_pkg;
  // data widths, fifo depth and counter width
  localparam int RESULT_W = 16;
  localparam int CONV_W = 14;
  localparam int CMD_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int CNT_W = 4;

  // timing: successive approximation length in divided clocks
  localparam logic [CNT_W-1:0] SAR_CYCLES = 4'hE;

  // system clock and internal oscillator rates
  localparam longint CLK_HZ = 125_000_000;
  localparam longint OSC_HZ = 2_500_000;
  // half period rounds down so the oscillator never runs slow
  localparam logic [7:0] OSC_HALF =
    8'((CLK_HZ / (2 * OSC_HZ)) > 0 ? (CLK_HZ / (2 * OSC_HZ)) : 1);

  // clock divide factor codes
  localparam logic [1:0] DIV_BY1 = 2'h0;
  localparam logic [1:0] DIV_BY2 = 2'h1;
  localparam logic [1:0] DIV_BY4 = 2'h2;
  localparam logic [1:0] DIV_BY8 = 2'h3;

  // synchroniser bit positions and reset value (chip select idles high)
  localparam int SY_MRST = 0;
  localparam int SY_EDGE = 1;
  localparam int SY_CONV = 2;
  localparam int SY_OSC = 3;
  localparam int SY_CPIN = 4;
  localparam int SY_SCLK = 5;
  localparam int SY_CSN = 6;
  localparam int SY_DIN = 7;
  localparam int SY_W = 8;
  localparam logic [SY_W-1:0] SYNC_RST = 8'h40;

  // conversion states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_SAR = 3'h2,
    ST_STORE = 3'h4
  } conv_state_e;

  // last count of the divider for a given factor code
  function automatic logic [2:0] div_last(input logic [1:0] code);
    case (code)
      DIV_BY1: div_last = 3'h0;
      DIV_BY2: div_last = 3'h1;
      DIV_BY4: div_last = 3'h3;
      default: div_last = 3'h7;
    endcase
  endfunction
endpackage

// ===== core/fifo_if.sv
// valid/ready carrier between the control block and its result fifo
`timescale 1ns/1ps
interface fifo_if #(parameter int W = 16);
  logic wr_valid;
  logic wr_ready;
  logic [W-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [W-1:0] rd_data;
  modport store (
    input wr_valid, wr_data, rd_ready,
    output wr_ready, rd_valid, rd_data
  );
  modport user (
    output wr_valid, wr_data, rd_ready,
    input wr_ready, rd_valid, rd_data
  );
endinterface

// ===== core/result_fifo.sv
// parameterised result fifo with valid/ready on both sides
`timescale 1ns/1ps
module result_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic clear,
  // both sides
  fifo_if.store port
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign port.wr_ready = (cnt_r != (AW+1)'(DEPTH));
  assign port.rd_valid = (cnt_r != '0);
  assign port.rd_data = mem[rp_r];
  assign push = port.wr_valid & port.wr_ready;
  assign pop = port.rd_valid & port.rd_ready;

  always_comb begin
    wp_nxt = push ? AW'(wp_r + 1'b1) : wp_r;
    rp_nxt = pop ? AW'(rp_r + 1'b1) : rp_r;
    cnt_nxt = (AW+1)'(cnt_r + push - pop);
    if (clear) begin
      wp_nxt = '0;
      rp_nxt = '0;
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage has no reset; occupancy guards every read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= port.wr_data;
    end
  end
endmodule // result_fifo

// ===== core/adc_pin_control_interface.sv
// pin level control of the converter: reset, clocks, trigger, serial port
`timescale 1ns/1ps
module adc_pin_control_interface
  import adc_ctl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // control pins
  input wire logic master_reset,
  input wire logic edge_select,
  input wire logic convert,
  output logic busy,
  input wire logic internal_osc_select,
  // configuration bits
  input wire logic internal_osc_select_bit,
  input wire logic [1:0] clock_divide_factor,
  input wire logic two_wire_mode,
  // conversion clock pin
  input wire logic conv_clock_pin_in,
  output logic conv_clock_pin_out,
  output logic conv_clock_pin_oe_n,
  // analog result from the converter core
  input wire logic [CONV_W-1:0] sample_data,
  // serial pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din_in,
  output logic din_out,
  output logic din_oe_n,
  output logic dout,
  output logic dout_oe_n,
  // received command bytes
  output logic [CMD_W-1:0] cmd_byte,
  output logic cmd_valid
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [SY_W-1:0] s1_r, s2_r;
  logic mrst, edge_s, conv_s, osc_s, cpin_s, sclk_s, csn_s, din_s;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_r <= SYNC_RST;
      s2_r <= SYNC_RST;
    end else begin
      s1_r <= {din_in, cs_n, sclk, conv_clock_pin_in, internal_osc_select,
               convert, edge_select, master_reset};
      s2_r <= s1_r;
    end
  end
  assign mrst = s2_r[SY_MRST];
  assign edge_s = s2_r[SY_EDGE];
  assign conv_s = s2_r[SY_CONV];
  assign osc_s = s2_r[SY_OSC];
  assign cpin_s = s2_r[SY_CPIN];
  assign sclk_s = s2_r[SY_SCLK];
  assign csn_s = s2_r[SY_CSN];
  assign din_s = s2_r[SY_DIN];

  ////////////////////////////////////////////////////////////////////////////
  // oscillator, pin sensing and divider
  logic osc_on, cpin_tick, div_tick;
  logic [7:0] ocnt_r, ocnt_nxt;
  logic osc_r, osc_nxt, cpin_prev_r, cpin_prev_nxt;
  logic [2:0] div_r, div_nxt;

  assign osc_on = osc_s | internal_osc_select_bit;
  assign cpin_tick = cpin_s & ~cpin_prev_r;
  assign div_tick = cpin_tick && (div_r == div_last(clock_divide_factor));

  always_comb begin
    ocnt_nxt = 8'(ocnt_r + 1'b1);
    osc_nxt = osc_r;
    cpin_prev_nxt = cpin_s;
    div_nxt = div_r;
    if (ocnt_r == 8'(OSC_HALF - 1'b1)) begin
      ocnt_nxt = 8'h00;
      osc_nxt = ~osc_r;
    end
    // clock is sensed back at the pin in both directions; a divider
    // change is compared at once, so it can take effect mid-count
    if (cpin_tick) begin
      div_nxt = div_tick ? 3'h0 : 3'(div_r + 1'b1);
    end
    if (!osc_on) begin
      ocnt_nxt = 8'h00;
      osc_nxt = 1'b0;
    end
    if (mrst) begin
      ocnt_nxt = 8'h00;
      osc_nxt = 1'b0;
      div_nxt = 3'h0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ocnt_r <= 8'h00;
      osc_r <= 1'b0;
      cpin_prev_r <= 1'b0;
      div_r <= 3'h0;
    end else begin
      ocnt_r <= ocnt_nxt;
      osc_r <= osc_nxt;
      cpin_prev_r <= cpin_prev_nxt;
      div_r <= div_nxt;
    end
  end
  assign conv_clock_pin_out = osc_r;
  assign conv_clock_pin_oe_n = ~osc_on;

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencing (chip select plays no part here)
  // no chip select term
  fifo_if #(.W(RESULT_W)) fq ();
  conv_state_e st_r, st_nxt;
  logic [CNT_W-1:0] sar_r, sar_nxt;
  logic conv_lvl_r, conv_lvl_nxt, busy_r, busy_nxt, trig_edge;
  logic [RESULT_W-1:0] res_r, res_nxt;

  assign trig_edge = div_tick & conv_s & ~conv_lvl_r;

  always_comb begin
    st_nxt = st_r;
    sar_nxt = sar_r;
    res_nxt = res_r;
    conv_lvl_nxt = div_tick ? conv_s : conv_lvl_r;
    case (st_r)
      ST_IDLE: begin
        if (trig_edge) begin
          st_nxt = ST_SAR;
          sar_nxt = '0;
        end
      end
      ST_SAR: begin
        if (div_tick) begin
          sar_nxt = CNT_W'(sar_r + 1'b1);
          if (sar_r == CNT_W'(SAR_CYCLES - 1'b1)) begin
            st_nxt = ST_STORE;
            res_nxt = RESULT_W'(sample_data);
          end
        end
      end
      ST_STORE: begin
        // full fifo holds busy high, the back-pressure on new triggers
        if (fq.wr_ready) begin
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
    if (mrst) begin
      st_nxt = ST_IDLE;
      sar_nxt = '0;
      res_nxt = '0;
      conv_lvl_nxt = 1'b0;
    end
    busy_nxt = (st_nxt != ST_IDLE);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= ST_IDLE;
      sar_r <= '0;
      res_r <= '0;
      conv_lvl_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      sar_r <= sar_nxt;
      res_r <= res_nxt;
      conv_lvl_r <= conv_lvl_nxt;
      busy_r <= busy_nxt;
    end
  end
  assign busy = busy_r;
  assign fq.wr_valid = (st_r == ST_STORE) & ~mrst;
  assign fq.wr_data = res_r;

  result_fifo #(.W(RESULT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .clear(mrst),
    .port(fq.store)
  );

  ////////////////////////////////////////////////////////////////////////////
  // serial port, clocked by clk and stepped by sampled serial clock edges
  logic sclk_prev_r, csn_prev_r, sclk_act, cs_fall;
  logic [CMD_W-1:0] rx_r, rx_nxt, cmd_r, cmd_nxt;
  logic [2:0] rxc_r, rxc_nxt;
  logic cval_r, cval_nxt;
  logic [RESULT_W-1:0] tx_r, tx_nxt;

  assign sclk_act = edge_s ? (sclk_s & ~sclk_prev_r) : (~sclk_s & sclk_prev_r);
  assign cs_fall = ~csn_s & csn_prev_r;
  assign fq.rd_ready = cs_fall & ~mrst;

  always_comb begin
    rx_nxt = rx_r;
    rxc_nxt = rxc_r;
    cmd_nxt = cmd_r;
    cval_nxt = 1'b0;
    tx_nxt = tx_r;
    // serial side counts only serial clock edges
    if (cs_fall) begin
      rxc_nxt = 3'h0;
      tx_nxt = fq.rd_valid ? fq.rd_data : '0;
    end else if (!csn_s && sclk_act) begin
      // one edge shifts in and out
      rx_nxt = {rx_r[CMD_W-2:0], din_s};
      tx_nxt = {tx_r[RESULT_W-2:0], 1'b0};
      rxc_nxt = 3'(rxc_r + 1'b1);
      if (rxc_r == 3'h7) begin
        cmd_nxt = {rx_r[CMD_W-2:0], din_s};
        cval_nxt = 1'b1;
      end
    end
    // chip select high ignores serial clock
    if (mrst) begin
      rx_nxt = '0;
      rxc_nxt = 3'h0;
      cmd_nxt = '0;
      cval_nxt = 1'b0;
      tx_nxt = '0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclk_prev_r <= 1'b0;
      csn_prev_r <= 1'b1;
      rx_r <= '0;
      rxc_r <= 3'h0;
      cmd_r <= '0;
      cval_r <= 1'b0;
      tx_r <= '0;
    end else begin
      sclk_prev_r <= sclk_s;
      csn_prev_r <= csn_s;
      rx_r <= rx_nxt;
      rxc_r <= rxc_nxt;
      cmd_r <= cmd_nxt;
      cval_r <= cval_nxt;
      tx_r <= tx_nxt;
    end
  end
  assign cmd_byte = cmd_r;
  assign cmd_valid = cval_r;
  assign dout = tx_r[RESULT_W-1];
  assign din_out = tx_r[RESULT_W-1];
  assign dout_oe_n = csn_s;
  // data-in drives only in 2-wire mode while selected
  assign din_oe_n = ~(two_wire_mode & ~csn_s);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [CNT_W:0] tick_cnt_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= (st_r != ST_SAR) ? '0 :
                    (CNT_W+1)'(tick_cnt_r + div_tick);
    end
  end

  a_busy_after_trig: assert property (
    st_r == ST_IDLE && trig_edge && !mrst |=> busy && st_r == ST_SAR)
    else $error("busy did not rise after trigger");
  a_busy_until_store: assert property (
    busy && !mrst |-> st_r != ST_IDLE)
    else $error("busy high while idle");
  a_sar_length: assert property (
    st_r == ST_SAR && !mrst ##1 st_r == ST_STORE |-> $past(tick_cnt_r) ==
    (CNT_W+1)'(SAR_CYCLES - 1'b1) && $past(div_tick))
    else $error("approximation phase length wrong");
  a_trig_single: assert property (
    trig_edge |-> ##1 !trig_edge)
    else $error("trigger fired twice");
  a_dout_cs_drive: assert property (
    $rose(csn_s) |-> dout_oe_n ##1 dout_oe_n || !csn_s)
    else $error("data-out driven while deselected");
  a_din_three_wire: assert property (
    !two_wire_mode || csn_s |-> din_oe_n && din_out == dout)
    else $error("data-in driven in 3-wire or deselected");
  a_edge_shift: assert property (
    sclk_act && !csn_s && !cs_fall && !mrst |=>
    rx_r == {$past(rx_r[CMD_W-2:0]), $past(din_s)})
    else $error("shift on wrong serial edge");
  a_cs_ignored: assert property (
    csn_s && !mrst |=> $stable(rx_r) && $stable(tx_r) && !cmd_valid)
    else $error("serial activity while deselected");
  a_conv_cs_free: assert property (
    st_r == ST_SAR && $rose(csn_s) && !mrst |-> ##1 st_r != ST_IDLE)
    else $error("chip select disturbed conversion");
  a_osc_pin_dir: assert property (
    $rose(osc_s) |-> !conv_clock_pin_oe_n ##[1:2] 1'b1)
    else $error("oscillator not driven on pin");
  a_div_wrap: assert property (
    div_tick && !mrst |=> div_r == 3'h0)
    else $error("divider did not wrap");
  a_mrst_clear: assert property (
    mrst |=> !busy && tx_r == '0 && cmd_byte == '0 && !fq.rd_valid)
    else $error("master reset left state");

  c_conversion: cover property (st_r == ST_STORE && fq.wr_ready);
  c_command: cover property (cmd_valid);
  c_fifo_full: cover property (!fq.wr_ready);
  c_two_wire: cover property (!din_oe_n && sclk_act);
endmodule // adc_pin_control_interface

// ===== test/host_model.sv
// host side model: serial port master and external conversion clock
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic clk,
  // serial pins
  input wire logic edge_sel,
  input wire logic dout_w,
  input wire logic din_w,
  output logic sclk,
  output logic cs_n,
  output logic din_drv,
  // conversion clock wire
  output logic ext_clk
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din_drv = 1'b0;
    ext_clk = 1'b0;
    // free running external clock, 12 clk period
    forever #48 ext_clk = ~ext_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // idle level inactive, so first move is the active edge
  task automatic xfer(input logic [15:0] txb, output logic [15:0] rxb,
    output logic [15:0] pinb);
    int i;
    @(negedge clk);
    sclk = edge_sel ? 1'b0 : 1'b1;
    repeat (6) @(negedge clk);
    cs_n = 1'b0;
    for (i = 15; i >= 0; i--) begin
      din_drv = txb[i];
      repeat (6) @(negedge clk);
      rxb[i] = dout_w;
      pinb[i] = din_w;
      sclk = ~sclk;
      repeat (6) @(negedge clk);
      sclk = ~sclk;
    end
    repeat (6) @(negedge clk);
    cs_n = 1'b1;
    // released line must not keep showing the last bit
    din_drv = ~din_drv;
  endtask

  // serial clock activity with chip select high
  task automatic tog(input int n);
    repeat (n) begin
      repeat (6) @(negedge clk);
      sclk = ~sclk;
      din_drv = ~din_drv;
    end
  endtask
endmodule // host_model

// ===== test/adc_pin_control_interface_test.sv
// self-checking bench for the converter pin control block
`timescale 1ns/1ps
module adc_pin_control_interface_test;
  import adc_ctl_pkg::*;
  logic clk, resetn, master_reset, edge_select, convert, busy;
  logic internal_osc_select, internal_osc_select_bit, two_wire_mode;
  logic [1:0] clock_divide_factor;
  logic conv_clock_pin_out, conv_clock_pin_oe_n, conv_pin, ext_clk;
  logic [CONV_W-1:0] sample_data;
  logic sclk, cs_n, din_drv, din_w, din_out, din_oe_n, dout, dout_oe_n;
  logic dout_w, cmd_valid;
  logic [CMD_W-1:0] cmd_byte;
  logic [15:0] res_q[$];
  logic [CMD_W-1:0] cmd_q[$];
  int error_cnt = 0;
  int comparisons = 0;
  int seed = 24;
  int per = 12;
  int lo = 156;
  int i, cfg, n, k;
  logic osc_v;

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  assign conv_pin = conv_clock_pin_oe_n ? ext_clk : conv_clock_pin_out;
  assign dout_w = (dout_oe_n === 1'b0) ? dout : 1'bz;
  assign din_w = (din_oe_n === 1'b0) ? din_out : din_drv;

  adc_pin_control_interface uut (
    .clk(clk), .resetn(resetn), .master_reset(master_reset),
    .edge_select(edge_select), .convert(convert), .busy(busy),
    .internal_osc_select(internal_osc_select),
    .internal_osc_select_bit(internal_osc_select_bit),
    .clock_divide_factor(clock_divide_factor),
    .two_wire_mode(two_wire_mode), .conv_clock_pin_in(conv_pin),
    .conv_clock_pin_out(conv_clock_pin_out),
    .conv_clock_pin_oe_n(conv_clock_pin_oe_n), .sample_data(sample_data),
    .sclk(sclk), .cs_n(cs_n), .din_in(din_w), .din_out(din_out),
    .din_oe_n(din_oe_n), .dout(dout), .dout_oe_n(dout_oe_n),
    .cmd_byte(cmd_byte), .cmd_valid(cmd_valid)
  );

  host_model host (
    .clk(clk), .edge_sel(edge_select), .dout_w(dout_w), .din_w(din_w),
    .sclk(sclk), .cs_n(cs_n), .din_drv(din_drv), .ext_clk(ext_clk)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (error_cnt == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic tmo(input int cnt, input int lim);
    if (cnt >= lim) begin
      error_cnt++;
      $display("ERROR wait bound %0d used up", lim);
      give_verdict();
    end
  endtask

  task automatic wait_busy(input logic lvl, input int lim);
    n = 0;
    while (busy !== lvl && n < lim) begin
      @(negedge clk);
      n++;
    end
    tmo(n, lim);
  endtask

  // one conversion; stall means the fifo is full and busy must hold
  task automatic conv(input logic stall);
    sample_data = CONV_W'($random(seed));
    res_q.push_back({2'h0, sample_data});
    convert = 1'b1;
    wait_busy(1'b1, 2000);
    if (stall) begin
      repeat (3000) @(negedge clk);
      check("busy on full fifo", 16'(busy), 16'h1);
    end else begin
      wait_busy(1'b0, 30000);
      check("busy length", 16'(n >= lo), 16'h1);
      repeat (300) @(negedge clk);
      check("busy on held trigger", 16'(busy), 16'h0);
    end
    convert = 1'b0;
    repeat (500) @(negedge clk);
  endtask

  task automatic rd();
    logic [15:0] txb, rxb, pinb, e;
    txb = 16'($random(seed));
    if (!two_wire_mode) begin
      cmd_q.push_back(txb[15:8]);
      cmd_q.push_back(txb[7:0]);
    end
    e = (res_q.size() > 0) ? res_q.pop_front() : 16'h0;
    host.xfer(txb, rxb, pinb);
    check("serial result", rxb, e);
    if (two_wire_mode) check("din pin data", pinb, rxb);
    repeat (4) @(negedge clk);
    check("dout oe", 16'(dout_oe_n), 16'h1);
    check("din oe", 16'(din_oe_n), 16'h1);
  endtask

  // expected command bytes noted by the driver, compared here
  always @(negedge clk) begin
    if (cmd_valid === 1'b1) begin
      if (cmd_q.size() > 0)
        check("cmd byte", 16'(cmd_byte), 16'(cmd_q.pop_front()));
      else if (two_wire_mode !== 1'b1)
        check("unexpected cmd", 16'h1, 16'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    master_reset = 1'b0;
    edge_select = 1'b0;
    convert = 1'b0;
    internal_osc_select = 1'b0;
    internal_osc_select_bit = 1'b0;
    clock_divide_factor = 2'h0;
    two_wire_mode = 1'b0;
    sample_data = '0;
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    // fill the fifo: eight stored, ninth stalls until a read
    for (i = 0; i < 9; i++) conv(i == 8);
    for (i = 0; i < 9; i++) rd();
    check("busy after drain", 16'(busy), 16'h0);
    host.tog(16);
    rd();
    for (cfg = 1; cfg < 4; cfg++) begin
      clock_divide_factor = 2'(cfg);
      edge_select = cfg[0];
      two_wire_mode = cfg[1];
      internal_osc_select = (cfg == 2);
      internal_osc_select_bit = (cfg == 3);
      per = (cfg >= 2) ? 50 : 12;
      lo = 13 * (1 << cfg) * per;
      repeat (600) @(negedge clk);
      check("clock pin oe", 16'(conv_clock_pin_oe_n), 16'(cfg < 2));
      // oscillator toggles once per half period while enabled
      osc_v = conv_clock_pin_out;
      k = 0;
      repeat (100) begin
        @(negedge clk);
        if (conv_clock_pin_out !== osc_v) k++;
        osc_v = conv_clock_pin_out;
      end
      n = (cfg >= 2) ? 100 / OSC_HALF : 0;
      check("osc toggles", 16'(k), 16'(n));
      conv(1'b0);
      rd();
    end
    // master reset in mid conversion
    clock_divide_factor = 2'h0;
    edge_select = 1'b0;
    two_wire_mode = 1'b0;
    internal_osc_select = 1'b0;
    internal_osc_select_bit = 1'b0;
    sample_data = 14'h2A5C;
    repeat (600) @(negedge clk);
    convert = 1'b1;
    wait_busy(1'b1, 2000);
    master_reset = 1'b1;
    repeat (4) @(negedge clk);
    check("busy in reset", 16'(busy), 16'h0);
    check("cmd in reset", 16'(cmd_byte), 16'h0);
    master_reset = 1'b0;
    convert = 1'b0;
    repeat (600) @(negedge clk);
    rd();
    give_verdict();
  end
endmodule // adc_pin_control_interface_test
